/* verilog/fsp_sequencer.v */
/*
 Flash self-programming sequencer: table read/write path, write latches,
 flash address capture, keyed start and a timed erase/program operation
 driving an internal array model. An operation lasts OP_CYCLES plus one
 cycle per row word. Assumes the core gives one-cycle strobes and honours
 stall_o.
*/
`include "fsp_consts.vh"
module fsp_sequencer
#(
   parameter NUM_PANELS = `FSP_NUM_PANELS,
   parameter ROW_WORDS  = `FSP_ROW_WORDS,
   parameter PANEL_ROWS = `FSP_PANEL_ROWS,
   parameter OP_CYCLES  = `FSP_OP_CYCLES
)
(
   input  wire        clk_i,        // Instruction clock
   input  wire        resetn_i,     // Sync reset, active low
   input  wire        tbl_req_i,    // Table instruction strobe
   input  wire        tbl_write_i,  // 1 write, 0 read
   input  wire        tbl_high_i,   // 1 high byte op, 0 low half op
   input  wire        tbl_byte_i,   // 1 byte access, 0 word access
   input  wire [15:0] tbl_ea_i,     // Effective address from W register
   input  wire [15:0] tbl_wdata_i,  // Write data
   input  wire        page_wr_i,    // Table page register write
   input  wire [7:0]  page_data_i,  // Table page value
   input  wire        adr_lo_wr_i,  // Direct flash address low write
   input  wire        adr_up_wr_i,  // Direct flash address upper write
   input  wire [15:0] adr_data_i,   // Data for address writes
   input  wire        ctl_wr_i,     // Control register write
   input  wire [15:0] ctl_data_i,   // Control value
   input  wire        key_wr_i,     // Unlock key register write
   input  wire [7:0]  key_data_i,   // Key value
   output reg  [15:0] tbl_rdata_o,  // Table read result
   output wire        tbl_done_o,   // Table access complete
   output wire [15:0] ctl_rd_o,     // Control register readback
   output wire [15:0] adr_lo_o,     // Flash address low readback
   output wire [7:0]  adr_up_o,     // Flash address upper readback
   output wire [7:0]  page_o,       // Table page readback
   output wire        stall_o       // Core stall during operation
);
   // Geometry; word address holds one panel bit above the row and index bits
   localparam PANEL_WORDS = PANEL_ROWS * ROW_WORDS;  // [RL7]
   localparam MEM_WORDS   = NUM_PANELS * PANEL_WORDS;
   localparam ROW_W       = 5;
   localparam WA_W        = 13;
   // Erased cells read back as all ones
   localparam [23:0] ERASED = `FSP_ERASED_WORD;

   // Operation states; APPLY walks the row one word per edge
   localparam S_IDLE  = 2'b00;
   localparam S_BUSY  = 2'b01;
   localparam S_APPLY = 2'b10;

   // Word address from byte address: program words step by two
   function [WA_W-1:0] word_of;
      input [23:0] a;
      begin
         word_of = a[WA_W:1];
      end
   endfunction

   // Array model, pointers and table access capture
   reg [23:0] flash_mem [0:MEM_WORDS-1];
   reg [7:0]  page_r;
   reg [15:0] adr_lo_r;
   reg [7:0]  adr_up_r;
   reg [15:0] ctl_r;
   reg [1:0]  state_r;
   reg [31:0] cnt_r;
   reg [ROW_W-1:0] idx_r;
   reg        acc_r;
   reg        done_r;
   reg        acc_wr_r;
   reg        acc_hi_r;
   reg        acc_byte_r;
   reg [23:0] acc_addr_r;
   reg [15:0] acc_data_r;

   // Decoded addresses and start qualification
   wire       armed;
   wire       start_try;
   wire       start_ok;
   wire [23:0] full_addr;
   wire [23:0] op_addr;
   wire [WA_W-1:0] row_base;
   wire [23:0] lat_rd [0:NUM_PANELS-1];
   wire [23:0] mem_word;
   wire [2:0]  lanes;
   wire [23:0] wdata_al;
   wire [WA_W-1:0] op_word;    // Word address of the target row
   wire [WA_W-1:0] acc_word;   // Word address of the table access
   wire [WA_W-1:0] apply_word; // Array word written in APPLY
   wire [7:0]  rd_byte;        // Byte picked for a byte read
   wire        lat_pnl;        // Panel hit by the table access
   wire        tbl_take;       // Table request accepted this edge
   wire        last_word;      // Row walk at its final word
   wire        cnt_done;       // Operation timer expired
   integer     m;

   // Byte addresses turn into word addresses before any row or panel decode
   assign full_addr = {page_r, tbl_ea_i};                           // [RL6]
   assign op_addr   = {adr_up_r, adr_lo_r};
   assign op_word   = word_of(op_addr);
   assign acc_word  = word_of(acc_addr_r);
   assign row_base  = {op_word[WA_W-1:ROW_W], {ROW_W{1'b0}}};      // [RL1]
   assign apply_word = {row_base[WA_W-1:ROW_W], idx_r};
   assign lat_pnl   = acc_word[WA_W-1];
   // Table requests are dropped, not queued, while the core is stalled
   assign tbl_take  = tbl_req_i && (state_r == S_IDLE);
   assign start_try = ctl_wr_i && ctl_data_i[`FSP_CTL_START_BIT] && (state_r == S_IDLE);
   assign start_ok  = start_try && armed && ctl_data_i[`FSP_CTL_PERMIT_BIT]; // [RL19]
   // Timer and row walk end points
   assign cnt_done  = (cnt_r == 32'h00000000);
   assign last_word = (idx_r == ROW_WORDS - 1);

   // Any register write other than a key breaks the unlock sequence
   fsp_key_lock u_key
   (
      .clk_i      (clk_i),
      .resetn_i   (resetn_i),
      .key_wr_i   (key_wr_i),
      .key_data_i (key_data_i),
      .other_wr_i (page_wr_i | adr_lo_wr_i | adr_up_wr_i | (ctl_wr_i & ~start_try)),
      .consume_i  (start_try),
      .armed_o    (armed)
   );

   // Lane enables: low op hits lanes 0/1, high op lane 2; byte mode picks one
   assign lanes = acc_hi_r ? 3'h4 :
                  (acc_byte_r ? (acc_addr_r[0] ? 3'h2 : 3'h1) : 3'h3); // [RL5]
   assign wdata_al = acc_hi_r ? {acc_data_r[7:0], 16'h0000} :
                     (acc_byte_r ? {8'h00, acc_data_r[7:0], acc_data_r[7:0]}
                                 : {8'h00, acc_data_r});

   // One latch bank per panel
   // Written one edge after the request, so a back-to-back request cannot clobber it
   genvar g;
   generate
      for (g = 0; g < NUM_PANELS; g = g + 1)
      begin : g_panel
         fsp_latch_bank #(.ROW_WORDS(ROW_WORDS), .IDX_W(ROW_W)) u_lat
         (
            .clk_i    (clk_i),
            .resetn_i (resetn_i),
            .wr_i     (acc_r && acc_wr_r && (lat_pnl == g)),         // [RL12]
            .widx_i   (acc_word[ROW_W-1:0]),                         // [RL9] [RL10]
            .lane_i   (lanes),
            .wdata_i  (wdata_al),
            .ridx_i   (idx_r),
            .rdata_o  (lat_rd[g])
         );
      end
   endgenerate

   // Table access: captured in cycle one, completes in cycle two
   always @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         acc_r      <= 1'b0;
         done_r     <= 1'b0;
         acc_wr_r   <= 1'b0;
         acc_hi_r   <= 1'b0;
         acc_byte_r <= 1'b0;
         acc_addr_r <= 24'h000000;
         acc_data_r <= 16'h0000;
      end
      else
      begin
         acc_r  <= tbl_take;
         done_r <= acc_r;                                            // [RL12]
         // Fields hold until the next accepted request
         if (tbl_take)
         begin
            acc_wr_r   <= tbl_write_i;
            acc_hi_r   <= tbl_high_i;
            acc_byte_r <= tbl_byte_i;
            acc_addr_r <= full_addr;
            acc_data_r <= tbl_wdata_i;
         end
      end
   end
   // Done trails the capture by one edge; the array read is combinational
   assign tbl_done_o = done_r;
   assign mem_word   = flash_mem[acc_word];
   // Byte mode on a low op: address bit 0 picks the odd byte
   assign rd_byte    = acc_addr_r[0] ? mem_word[15:8] : mem_word[7:0];

   // Read data formed from the array word
   always @(posedge clk_i)
   begin
      if (!resetn_i)
         tbl_rdata_o <= 16'h0000;
      else if (acc_r && !acc_wr_r)
      begin
         if (acc_hi_r)
            tbl_rdata_o <= {8'h00, mem_word[23:16]};                  // [RL4]
         else if (acc_byte_r)
            tbl_rdata_o <= {8'h00, rd_byte};                          // [RL5]
         else
            tbl_rdata_o <= mem_word[15:0];                            // [RL3]
      end
   end

   // Pointer and address registers; table ops update flash address
   always @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         page_r   <= 8'h00;
         adr_lo_r <= 16'h0000;
         adr_up_r <= 8'h00;
      end
      else
      begin
         if (page_wr_i)
            page_r <= page_data_i;                                    // [RL14]
         if (tbl_take)
         begin
            adr_lo_r <= full_addr[15:0];                              // [RL17]
            adr_up_r <= full_addr[23:16];                             // [RL17]
         end
         else
         begin
            if (adr_lo_wr_i) adr_lo_r <= adr_data_i;
            if (adr_up_wr_i) adr_up_r <= adr_data_i[7:0];
         end
      end
   end

   // Control and operation timer; start bit self-clears at the end
   always @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         ctl_r   <= 16'h0000;
         state_r <= S_IDLE;
         cnt_r   <= 32'h00000000;
         idx_r   <= {ROW_W{1'b0}};
      end
      else
      begin
         case (state_r)
            S_IDLE:
            begin
               if (ctl_wr_i)
                  ctl_r <= {start_ok, ctl_data_i[14:0]};              // [RL13] [RL19]
               if (start_ok)
               begin
                  state_r <= S_BUSY;                                  // [RL16]
                  cnt_r   <= OP_CYCLES - 1;
               end
            end
            S_BUSY:
            begin
               if (cnt_done)
               begin
                  state_r <= S_APPLY;
                  idx_r   <= {ROW_W{1'b0}};
               end
               else
                  cnt_r <= cnt_r - 32'h00000001;
            end
            // Start bit drops on the same edge the state returns to idle
            S_APPLY:
            begin
               idx_r <= idx_r + 1'b1;
               if (last_word)
               begin
                  state_r                   <= S_IDLE;
                  ctl_r[`FSP_CTL_START_BIT] <= 1'b0;                  // [RL16] [RL20]
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // Array update, one word per cycle across the row
   always @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         for (m = 0; m < MEM_WORDS; m = m + 1)
            flash_mem[m] <= ERASED;
      end
      else if (state_r == S_APPLY)
      begin
         if (ctl_r[`FSP_CTL_ERASE_BIT])
            flash_mem[apply_word] <= ERASED;                          // [RL1]
         else
            flash_mem[apply_word] <= lat_rd[row_base[WA_W-1]];        // [RL2]
      end
   end

   // Readbacks come straight from their registers
   assign ctl_rd_o = ctl_r;                                           // [RL20]
   assign adr_lo_o = adr_lo_r;
   assign adr_up_o = adr_up_r;
   assign page_o   = page_r;
   assign stall_o  = (state_r != S_IDLE);                             // [RL16]
endmodule

/* verilog/fsp_consts.vh */
/*
 Constants for the flash self-programming sequencer: key values, control
 field positions, geometry and timing. Assumes a 200 MHz instruction clock.
*/
// Behaviour
// (RL1) Erase happens one whole row at a time: 32 words, 96 bytes.
// (RL2) Programming writes all 32 latched words of a row in one operation.
// (RL3) Low-half table accesses move program word bits 15..0.
// (RL4) High-byte table accesses move program word bits 23..16.
// (RL5) Every table access supports whole 16-bit word or single byte mode; high ops here ignore byte mode and always move the one high byte.
// (RL6) Address is table page byte above the 16-bit effective address.
// (RL7) Flash is split into panels of 128 rows, 4K words of 24 bits.
// (RL8) Each panel owns write latches holding 32 pending words.
// (RL9) Latches fill in ascending order, word 0 first.
// (RL10) Loader starts latch addresses on a 32-word boundary.
// (RL11) Loader issues 32 low and 32 high writes per row.
// (RL12) Table writes touch only latches, taking 2 instruction cycles.
// (RL13) Array changes only after the start bit in control is set.
// (RL14) Loader sets page and offset pointer before the table writes.
// (RL15) Keys 0x55 then 0xAA back to back unlock one operation.
// (RL16) Start bit 15 begins operation, stalls core about 2 ms, self-clears.
// (RL17) Flash address registers capture the last table instruction address.
// (RL18) Software selects erase or program and sets the write permit bit.
// (RL19) Start without the just-completed key sequence is ignored.
// (RL20) Start bit reads one while busy, zero once finished.
`ifndef FSP_CONSTS_VH
`define FSP_CONSTS_VH
`define FSP_KEY_FIRST      8'h55
`define FSP_KEY_SECOND     8'hAA
`define FSP_CTL_START_BIT  15
`define FSP_CTL_PERMIT_BIT 14
`define FSP_CTL_ERASE_BIT  6
`define FSP_ROW_WORDS      32
`define FSP_PANEL_ROWS     128
`define FSP_NUM_PANELS     2
`define FSP_OP_TIME_NS     2000000
`define FSP_CLK_PERIOD_NS  5
`define FSP_OP_CYCLES      (`FSP_OP_TIME_NS / `FSP_CLK_PERIOD_NS)
`define FSP_TBLWR_CYCLES   2
`define FSP_ERASED_WORD    24'hFFFFFF
`endif

/* verilog/fsp_key_lock.v */
/*
 Unlock key tracker. Arms after 0x55 then 0xAA on consecutive key writes.
 Assumes key and control writes arrive as one-cycle strobes on clk_i.
*/
`include "fsp_consts.vh"
module fsp_key_lock
(
   input  wire       clk_i,      // Instruction clock
   input  wire       resetn_i,   // Sync reset, active low
   input  wire       key_wr_i,   // Key register write strobe
   input  wire [7:0] key_data_i, // Key value written
   input  wire       other_wr_i, // Any other register write breaks sequence
   input  wire       consume_i,  // Start attempt uses up the arming
   output wire       armed_o     // Sequence just completed
);
   reg first_r;
   reg armed_r;

   // Any stray write between keys restarts the sequence
   always @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         first_r <= 1'b0;
         armed_r <= 1'b0;
      end
      else if (key_wr_i)
      begin
         first_r <= (key_data_i == `FSP_KEY_FIRST);                 // [RL15]
         armed_r <= first_r && (key_data_i == `FSP_KEY_SECOND);     // [RL15]
      end
      else if (other_wr_i || consume_i)
      begin
         first_r <= 1'b0;
         armed_r <= 1'b0;                                           // [RL19]
      end
   end

   assign armed_o = armed_r;
endmodule

/* verilog/fsp_latch_bank.v */
/*
 Per-panel write latches: one row of 24-bit words, byte-lane writable.
 Assumes the sequencer hands it a word index and lane enables.
*/
`include "fsp_consts.vh"
module fsp_latch_bank
#(
   parameter ROW_WORDS = `FSP_ROW_WORDS,
   parameter IDX_W     = 5
)
(
   input  wire             clk_i,     // Instruction clock
   input  wire             resetn_i,  // Sync reset, active low
   input  wire             wr_i,      // Latch write strobe
   input  wire [IDX_W-1:0] widx_i,    // Word index within row
   input  wire [2:0]       lane_i,    // Byte lanes 0,1 low half, 2 high byte
   input  wire [23:0]      wdata_i,   // Data aligned to program word
   input  wire [IDX_W-1:0] ridx_i,    // Word index for drain
   output wire [23:0]      rdata_o    // Latched word at ridx_i
);
   reg [23:0] lat_r [0:ROW_WORDS-1];  // [RL8]
   integer    k;

   // Latches only; the array is never touched here
   always @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         for (k = 0; k < ROW_WORDS; k = k + 1)
            lat_r[k] <= `FSP_ERASED_WORD;
      end
      else if (wr_i)
      begin
         if (lane_i[0]) lat_r[widx_i][7:0]   <= wdata_i[7:0];    // [RL3] [RL5]
         if (lane_i[1]) lat_r[widx_i][15:8]  <= wdata_i[15:8];   // [RL3] [RL5]
         if (lane_i[2]) lat_r[widx_i][23:16] <= wdata_i[23:16];  // [RL4] [RL12]
      end
   end

   assign rdata_o = lat_r[ridx_i];
endmodule

/* dv/fsp_core_model.sv */
/*
 Processor core model issuing table and control register accesses.
 Assumes one clock; drives on rising edges, samples on falling ones.
*/
module fsp_core_model
(
   input  wire         clk_i,   // Clock
   input  wire         stall_i, // Core stall
   input  wire         done_i,  // Table done
   input  wire  [15:0] rdata_i, // Read data
   output logic        req_o,   // Table strobe
   output logic        wr_o,    // Write op
   output logic        hi_o,    // High op
   output logic [15:0] ea_o,    // Address
   output logic [15:0] wd_o,    // Write data
   output logic        pgw_o,   // Page write
   output logic [7:0]  pg_o,    // Page value
   output logic        ctw_o,   // Control write
   output logic [15:0] ct_o,    // Control value
   output logic        kyw_o,   // Key write
   output logic [7:0]  ky_o,    // Key value
   output logic        hung_o   // Wait ran out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] cur_pg; // Page last written
   // Idle values at time zero
   initial
   begin
      {req_o, wr_o, hi_o, pgw_o, ctw_o, kyw_o, hung_o} = '0;
      {ea_o, wd_o, pg_o, ct_o, ky_o, cur_pg} = '0;
   end
   // Core is frozen while stalled, so nothing issues then
   task automatic wait_idle;
      int n;
      for (n = 0; n < 200 && stall_i !== 1'b0; n++) @(negedge clk_i);
      if (n == 200) hung_o = 1;
   endtask
   // Released data lines are inverted so stale values never look valid
   task automatic tbl(input logic w, h, input logic [15:0] ea, wd,
                      output logic [15:0] rd);
      int n;
      wait_idle();
      @(posedge clk_i);
      {req_o, wr_o, hi_o, ea_o, wd_o} <= {1'b1, w, h, ea, wd};
      @(posedge clk_i);
      {req_o, ea_o, wd_o} <= {1'b0, ~ea, ~wd};
      for (n = 0; n < 4 && done_i !== 1'b1; n++) @(negedge clk_i);
      if (n == 4) hung_o = 1;
      rd = rdata_i;
   endtask
   // Pointer set before latch loads
   task automatic set_page(input logic [7:0] p);
      @(posedge clk_i);
      {pgw_o, pg_o, cur_pg} <= {1'b1, p, p};
      @(posedge clk_i);
      {pgw_o, pg_o} <= {1'b0, ~p};
   endtask
   // Mode 0 no keys, 1 keys back to back, 2 keys split by a page write
   task automatic start(input logic [15:0] ctl, input int mode);
      wait_idle();
      if (mode > 0)
      begin
         @(posedge clk_i);
         {kyw_o, ky_o} <= {1'b1, 8'h55};
         if (mode == 2)
         begin
            @(posedge clk_i);
            {kyw_o, pgw_o, pg_o} <= {1'b0, 1'b1, cur_pg};
         end
         @(posedge clk_i);
         {pgw_o, kyw_o, ky_o} <= {1'b0, 1'b1, 8'hAA};
      end
      @(posedge clk_i);
      {kyw_o, ky_o, ctw_o, ct_o} <= {1'b0, 8'h55, 1'b1, ctl};
      @(posedge clk_i);
      {ctw_o, ct_o} <= {1'b0, ~ctl};
      @(negedge clk_i); // Let the start attempt settle before anyone looks
   endtask
endmodule

/* dv/fsp_seq_chk.sv */
/*
 Port checker for the sequencer.
 Assumes it is bound into fsp_sequencer with one clock domain.
*/
module fsp_seq_chk
#(
   parameter OP_CYCLES = 20
)
(
   input wire        clk_i,       // Clock
   input wire        resetn_i,    // Sync reset
   input wire        tbl_req_i,   // Table strobe
   input wire [15:0] tbl_ea_i,    // Address
   input wire        page_wr_i,   // Page write
   input wire        adr_lo_wr_i, // Address low write
   input wire        adr_up_wr_i, // Address upper write
   input wire        ctl_wr_i,    // Control write
   input wire [15:0] ctl_data_i,  // Control value
   input wire        key_wr_i,    // Key write
   input wire [7:0]  key_data_i,  // Key value
   input wire        tbl_done_o,  // Table done
   input wire [15:0] ctl_rd_o,    // Control readback
   input wire [15:0] adr_lo_o,    // Address low
   input wire [7:0]  adr_up_o,    // Address upper
   input wire [7:0]  page_o,      // Page readback
   input wire        stall_o      // Core stall
);
   logic [19:0] stall_cnt_r; // Cycles stalled so far
   logic        key_ok_r;    // Last write was the closing key
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // Key follower holds across idle cycles; any other register write breaks it
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
         key_ok_r <= 1'b0;
      else if (key_wr_i)
         key_ok_r <= key_data_i == 8'hAA;
      else if (ctl_wr_i || page_wr_i || adr_lo_wr_i || adr_up_wr_i)
         key_ok_r <= 1'b0;
   end
   // Stall length counter
   always_ff @(posedge clk_i)
   begin
      stall_cnt_r <= (resetn_i && stall_o) ? stall_cnt_r + 20'h00001 : 20'h00000;
   end
   a_done_timing: assert property (tbl_done_o == ($past(tbl_req_i, 2) && !$past(stall_o, 2)))
      else $error("table done not two cycles after accepted request");
   a_addr_capture: assert property (tbl_req_i && !stall_o |=> adr_lo_o == $past(tbl_ea_i))
      else $error("address low not captured");
   a_page_capture: assert property (tbl_req_i && !stall_o |=> adr_up_o == $past(page_o))
      else $error("address upper not taken from page");
   a_keyed_start: assert property (ctl_wr_i && (ctl_data_i[15:14] == 2'b11) && key_ok_r
      && $past(key_wr_i, 2) && $past(key_data_i, 2) == 8'h55 && !stall_o |=> stall_o && ctl_rd_o[15])
      else $error("keyed start did not begin");
   a_unkeyed_ignored: assert property (ctl_wr_i && !key_ok_r && !stall_o |=> !stall_o)
      else $error("start taken without keys");
   a_permit_needed: assert property (ctl_wr_i && !ctl_data_i[14] && !stall_o |=> !stall_o)
      else $error("start taken without permit");
   a_stall_length: assert property ($fell(stall_o) |-> stall_cnt_r == OP_CYCLES + 32)
      else $error("operation length wrong");
   a_stall_bound: assert property (stall_o |-> stall_cnt_r < OP_CYCLES + 32)
      else $error("operation overran");
   a_busy_readback: assert property (ctl_rd_o[15] == stall_o)
      else $error("start bit does not follow busy");
endmodule
bind fsp_sequencer fsp_seq_chk #(.OP_CYCLES(OP_CYCLES)) fsp_seq_chk_inst (.clk_i, .resetn_i,
   .tbl_req_i, .tbl_ea_i, .page_wr_i, .adr_lo_wr_i, .adr_up_wr_i, .ctl_wr_i, .ctl_data_i,
   .key_wr_i, .key_data_i, .tbl_done_o, .ctl_rd_o, .adr_lo_o, .adr_up_o, .page_o, .stall_o);

/* dv/tb_top.sv */
/*
 Testbench for the sequencer: erase, latch load, refused and keyed starts.
 Assumes the core model drives requests, the bench byte mode; direct address
 writes unused.
*/
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam OPC = 20;         // Short operation for simulation
   localparam ROW = 16'h0040;   // Row 1, on a 32-word boundary
   logic        clk_i, resetn_i, tbl_byte_i;
   wire         tbl_req_i, tbl_write_i, tbl_high_i, page_wr_i, ctl_wr_i, key_wr_i, hung;
   wire  [15:0] tbl_ea_i, tbl_wdata_i, ctl_data_i, tbl_rdata_o, ctl_rd_o, adr_lo_o;
   wire  [7:0]  page_data_i, key_data_i, adr_up_o, page_o;
   wire         tbl_done_o, stall_o;
   int          n_fail, checked;
   // Direct address writes are left idle; byte mode comes from the bench
   fsp_sequencer #(.OP_CYCLES(OPC)) fsp_sequencer_inst (.clk_i, .resetn_i, .tbl_req_i,
      .tbl_write_i, .tbl_high_i, .tbl_byte_i, .tbl_ea_i, .tbl_wdata_i, .page_wr_i,
      .page_data_i, .adr_lo_wr_i(1'b0), .adr_up_wr_i(1'b0), .adr_data_i(16'h0000), .ctl_wr_i,
      .ctl_data_i, .key_wr_i, .key_data_i, .tbl_rdata_o, .tbl_done_o, .ctl_rd_o, .adr_lo_o,
      .adr_up_o, .page_o, .stall_o);
   fsp_core_model fsp_core_model_inst (.clk_i, .stall_i(stall_o), .done_i(tbl_done_o),
      .rdata_i(tbl_rdata_o), .req_o(tbl_req_i), .wr_o(tbl_write_i), .hi_o(tbl_high_i),
      .ea_o(tbl_ea_i), .wd_o(tbl_wdata_i), .pgw_o(page_wr_i), .pg_o(page_data_i),
      .ctw_o(ctl_wr_i), .ct_o(ctl_data_i), .kyw_o(key_wr_i), .ky_o(key_data_i), .hung_o(hung));
   task automatic check(input logic [23:0] seen, exp, input string what);
      checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask
   task automatic conclude;
      if (n_fail == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Keyed start, busy while running, then read the row back
   task automatic t_run(input logic [15:0] ctl, input logic ers);
      logic [15:0] rd;
      fsp_core_model_inst.start(ctl, 1);
      @(negedge clk_i);
      check(ctl_rd_o[15], 1, "busy not set");
      fsp_core_model_inst.wait_idle();
      check(ctl_rd_o[15], 0, "busy not cleared");
      for (int i = 0; i < 32; i++)
      begin
         fsp_core_model_inst.tbl(0, 0, ROW + 16'(2 * i), 16'h0000, rd);
         check(rd, ers ? 16'hFFFF : 16'hA500 + 16'(i), "low half");
         fsp_core_model_inst.tbl(0, 1, ROW + 16'(2 * i), 16'h0000, rd);
         check(rd[7:0], ers ? 8'hFF : 8'h30 + 8'(i), "high byte");
      end
   endtask
   // Latch load ascending from the row start; array must stay blank
   task automatic t_load;
      logic [15:0] rd;
      fsp_core_model_inst.set_page(8'h00);
      for (int i = 0; i < 32; i++)
      begin
         fsp_core_model_inst.tbl(1, 0, ROW + 16'(2 * i), 16'hA500 + 16'(i), rd);
         fsp_core_model_inst.tbl(1, 1, ROW + 16'(2 * i), 16'h5A30 + 16'(i), rd);
      end
      check(adr_lo_o, ROW + 16'h003E, "address low capture");
      fsp_core_model_inst.tbl(0, 0, ROW, 16'h0000, rd);
      check(rd, 16'hFFFF, "latch write reached array");
   endtask
   // Starts missing keys, broken keys or permit are all ignored
   task automatic t_refused;
      logic [15:0] rd;
      fsp_core_model_inst.start(16'hC000, 0);
      check(stall_o, 0, "start without keys");
      fsp_core_model_inst.start(16'hC000, 2);
      check(stall_o, 0, "start with broken keys");
      fsp_core_model_inst.start(16'h8000, 1);
      check(stall_o, 0, "start without permit");
      fsp_core_model_inst.tbl(0, 0, ROW, 16'h0000, rd);
      check(rd, 16'hFFFF, "array changed without start");
   endtask
   // Byte reads of a low op pick one byte by address bit 0
   task automatic t_byte;
      logic [15:0] rd;
      @(posedge clk_i);
      tbl_byte_i <= 1'b1;
      fsp_core_model_inst.tbl(0, 0, ROW + 16'h0002, 16'h0000, rd);
      check(rd, 16'h0001, "even byte read");
      fsp_core_model_inst.tbl(0, 0, ROW + 16'h0003, 16'h0000, rd);
      check(rd, 16'h00A5, "odd byte read");
      @(posedge clk_i);
      tbl_byte_i <= 1'b0;
   endtask
   // Page byte lands above the effective address
   task automatic t_pointer;
      logic [15:0] rd;
      fsp_core_model_inst.set_page(8'h5A);
      fsp_core_model_inst.tbl(0, 0, 16'h1234, 16'h0000, rd);
      check({adr_up_o, adr_lo_o}, 24'h5A1234, "page and address capture");
   endtask
   initial
   begin
      clk_i = 0;
      forever #2.5 clk_i = ~clk_i;
   end
   // A model wait that ran out ends the run
   always @(posedge hung)
   begin
      n_fail++;
      conclude();
   end
   initial
   begin
      resetn_i = 0;
      tbl_byte_i = 1'b0;
      repeat (2) @(posedge clk_i);
      resetn_i <= 1;
      @(negedge clk_i);
      check({ctl_rd_o, page_o}, 24'h000000, "reset state");
      check(stall_o, 0, "reset stall");
      t_load();
      t_refused();
      t_run(16'hC000, 0);
      t_byte();
      t_run(16'hC040, 1);
      t_pointer();
      conclude();
   end
endmodule
